// >>> phys_mem_access_checker_regs.svh
`ifndef PHYS_MEM_ACCESS_CHECKER_REGS_SVH
`define PHYS_MEM_ACCESS_CHECKER_REGS_SVH

// register map, byte addresses
`define PMAC_CFG_BASE       12'h000
`define PMAC_ADDR_BASE      12'h100
`define PMAC_STATUS_OFS     12'h200
`define PMAC_FAULT_ADDR_OFS 12'h204
`define PMAC_FAULT_CNT_OFS  12'h208
`define PMAC_REGION_LSB     8
`define PMAC_IDX_LSB        2

// entry configuration byte fields
`define PMAC_CFG_R          0
`define PMAC_CFG_W          1
`define PMAC_CFG_X          2
`define PMAC_CFG_A_LSB      3
`define PMAC_CFG_L          7
`define PMAC_CFG_KEEP_MASK  8'h9F

// status register fields
`define PMAC_ST_FAULT       0
`define PMAC_ST_KIND_LSB    1
`define PMAC_ST_INSN_FAULT  3

// reset values
`define PMAC_CFG_RST        8'h00
`define PMAC_ADDR_RST       32'h0000_0000

// bus answers
`define PMAC_RESP_OKAY      2'h0
`define PMAC_RESP_SLVERR    2'h2

// largest entry count that the map can hold
`define PMAC_MAX_ENTRIES    64

`endif

// >>> phys_mem_access_checker_pkg.sv
package phys_mem_access_checker_pkg;

  typedef enum logic [1:0] {
    MATCH_OFF        = 2'b00,
    RANGE_TOP_MATCH  = 2'b01,
    ALIGNED_QUAD_BYTE_MATCH = 2'b10,
    ALIGNED_POW2_MATCH      = 2'b11
  } match_mode_t;

  typedef enum logic [1:0] {
    ACC_FETCH = 2'b00,
    ACC_LOAD  = 2'b01,
    ACC_STORE = 2'b10
  } access_kind_t;

  typedef enum logic [1:0] {
    PRIV_USER       = 2'b00,
    PRIV_SUPERVISOR = 2'b01,
    PRIV_MACHINE    = 2'b11
  } priv_t;

  typedef enum logic [1:0] {
    FAULT_INSN  = 2'b00,
    FAULT_LOAD  = 2'b01,
    FAULT_STORE = 2'b10
  } fault_kind_t;

endpackage : phys_mem_access_checker_pkg

// >>> region_match.sv
`timescale 1ns/10ps
`include "phys_mem_access_checker_regs.svh"

module region_match #(
  parameter int PA_W = 34
) (
  // entry setting
  input  wire logic [1:0]      i_mode,
  input  wire logic [PA_W-3:0] i_addr,
  input  wire logic [PA_W-3:0] i_prev_addr,
  input  wire logic            i_first,
  // access byte span, inclusive
  input  wire logic [PA_W:0]   i_lo,
  input  wire logic [PA_W:0]   i_hi,
  // result
  output logic                 o_any,
  output logic                 o_full
);

  wire logic [PA_W-3:0] ones_mask = i_addr ^ (i_addr + {{(PA_W-3){1'b0}}, 1'b1});
  wire logic [PA_W:0]   own_byte  = {1'b0, i_addr, 2'b00};
  wire logic [PA_W:0]   prev_byte = i_first ? '0 : {1'b0, i_prev_addr, 2'b00};
  wire logic [PA_W:0]   pow2_span = {1'b0, ones_mask, 2'b11};
  wire logic [PA_W:0]   pow2_base = own_byte & ~pow2_span;
  logic      [PA_W:0]   base;
  logic      [PA_W:0]   top;

  always_comb begin
    case (i_mode)
      2'b01: begin
        base = prev_byte;
        top  = own_byte;
      end
      2'b10: begin
        base = own_byte;
        top  = own_byte + (PA_W+1)'(4);
      end
      2'b11: begin
        base = pow2_base;
        top  = pow2_base + pow2_span + (PA_W+1)'(1);
      end
      default: begin
        base = '0;
        top  = '0;
      end
    endcase
  end

  // empty or inverted span matches nothing
  wire logic span_ok = base < top;
  assign o_any  = span_ok && (i_lo < top) && (i_hi >= base);
  assign o_full = span_ok && (i_lo >= base) && (i_hi < top);

endmodule : region_match

// >>> phys_mem_access_checker.sv
`timescale 1ns/10ps
`include "phys_mem_access_checker_regs.svh"

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - lowest-numbered entry touching any access byte alone decides the outcome.
// - deciding entry covering only part of the access makes the access fail.
// - unlocked full match at machine privilege passes without permission bits.
// - locked entry or lower privilege passes only with the matching permission bit.
// - machine access matching no entry passes.
// - lower-privilege access matching nothing fails when any entry exists.
// - failure reported as instruction, load or store fault by access type.
// - instruction faults if any of its accesses failed, even after others passed.
// - misaligned accesses may be split; each part checked on its own.
// - stores wider than native_reg_width may be split and checked per part.
// - every physical access, page-table reads included, goes through the check.
// - page-table walk accesses are checked at supervisor privilege.
// - results may be computed any time between translation and access.
// - current settings are evaluated on each access, nothing is cached.
// - mode field selects off, range_top, aligned_quad_byte, aligned_pow2.
// - range_top spans previous address to own; entry zero from zero.
// - trailing ones in address set aligned_pow2 size starting at eight bytes.
// - lock freezes entry settings until reset and binds machine privilege.
module phys_mem_access_checker #(
  parameter int N_ENTRIES = 16,
  parameter int PA_W      = 34,
  parameter int SIZE_MAX  = 3,
  parameter int AXI_AW    = 12
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // axi4-lite write address
  input  wire logic              i_axi_awvalid,
  output logic                   o_axi_awready,
  input  wire logic [AXI_AW-1:0] i_axi_awaddr,
  // axi4-lite write data
  input  wire logic              i_axi_wvalid,
  output logic                   o_axi_wready,
  input  wire logic [31:0]       i_axi_wdata,
  input  wire logic [3:0]        i_axi_wstrb,
  // axi4-lite write response
  output logic                   o_axi_bvalid,
  input  wire logic              i_axi_bready,
  output logic [1:0]             o_axi_bresp,
  // axi4-lite read address
  input  wire logic              i_axi_arvalid,
  output logic                   o_axi_arready,
  input  wire logic [AXI_AW-1:0] i_axi_araddr,
  // axi4-lite read data
  input  wire logic              i_axi_rready,
  output logic                   o_axi_rvalid,
  output logic [31:0]            o_axi_rdata,
  output logic [1:0]             o_axi_rresp,
  // access check request
  input  wire logic              i_chk_valid,
  input  wire logic [PA_W-1:0]   i_chk_addr,
  input  wire logic [1:0]        i_chk_size,
  input  wire logic [1:0]        i_chk_kind,
  input  wire logic [1:0]        i_chk_priv,
  input  wire logic              i_chk_walk,
  input  wire logic              i_chk_last,
  // access check result
  output logic                   o_chk_done,
  output logic                   o_chk_fault,
  output logic [1:0]             o_chk_cause,
  // instruction-level result
  output logic                   o_insn_done,
  output logic                   o_insn_fault
);

  localparam int NE = (N_ENTRIES > 0) ? N_ENTRIES : 1;

  initial begin
    if (!(N_ENTRIES == 0 || N_ENTRIES == 16 || N_ENTRIES == `PMAC_MAX_ENTRIES))
      $error("N_ENTRIES must be 0, 16 or 64");
    if (PA_W < 10 || PA_W > 34)
      $error("PA_W must be 10 to 34");
    if (SIZE_MAX < 0 || SIZE_MAX > 3)
      $error("SIZE_MAX must be 0 to 3");
    if (AXI_AW < 10)
      $error("AXI_AW must be at least 10");
  end

  //////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction : merge_bytes

  // reserved bits zero, write without read not kept
  function automatic logic [7:0] legal_cfg(input logic [7:0] v);
    logic [7:0] res;
    res = v & `PMAC_CFG_KEEP_MASK;
    if (!res[`PMAC_CFG_R]) res[`PMAC_CFG_W] = 1'b0;
    return res;
  endfunction : legal_cfg

  //////////////////////////////////////////////////////////////////////////////
  // entry storage

  logic [7:0]      cfg_reg  [NE];
  logic [PA_W-3:0] addr_reg [NE];
  logic [NE-1:0]   cfg_lock;
  logic [NE-1:0]   addr_lock;

  genvar g;
  generate
    for (g = 0; g < NE; g++) begin : g_lock
      assign cfg_lock[g] = cfg_reg[g][`PMAC_CFG_L];
      if (g + 1 < NE) begin : g_next
        assign addr_lock[g] = cfg_reg[g][`PMAC_CFG_L] ||
          (cfg_reg[g+1][`PMAC_CFG_L] &&
           cfg_reg[g+1][`PMAC_CFG_A_LSB +: 2] ==
             phys_mem_access_checker_pkg::RANGE_TOP_MATCH);
      end else begin : g_last
        assign addr_lock[g] = cfg_reg[g][`PMAC_CFG_L];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  logic              aw_full_reg;
  logic              w_full_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;

  wire logic       aw_fire  = i_axi_awvalid && o_axi_awready;
  wire logic       w_fire   = i_axi_wvalid && o_axi_wready;
  wire logic       do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  wire logic [1:0] wr_region = awaddr_reg[`PMAC_REGION_LSB +: 2];
  wire logic [5:0] wr_idx    = awaddr_reg[`PMAC_IDX_LSB +: 6];
  wire logic       wr_entry  = ({26'h0, wr_idx} < N_ENTRIES) &&
                               (awaddr_reg[AXI_AW-1:`PMAC_REGION_LSB+2] == '0);
  wire logic       wr_cfg    = wr_entry && wr_region == 2'h0;
  wire logic       wr_addr   = wr_entry && wr_region == 2'h1;
  wire logic       wr_ok     = wr_cfg || wr_addr;

  assign o_axi_awready = !aw_full_reg;
  assign o_axi_wready  = !w_full_reg;
  assign o_axi_bvalid  = bvalid_reg;
  assign o_axi_bresp   = bresp_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end else begin
      if (aw_fire) begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= i_axi_awaddr;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      if (w_fire) begin
        w_full_reg <= 1'b1;
        wdata_reg  <= i_axi_wdata;
        wstrb_reg  <= i_axi_wstrb;
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `PMAC_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_ok ? `PMAC_RESP_OKAY : `PMAC_RESP_SLVERR;
    end else if (i_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // locked entries ignore writes until reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < NE; i++) begin
        cfg_reg[i]  <= `PMAC_CFG_RST;
        addr_reg[i] <= '0;
      end
    end else if (do_write) begin
      for (int i = 0; i < NE; i++) begin
        if (wr_cfg && wr_idx == 6'(i) && !cfg_lock[i] && wstrb_reg[0])
          cfg_reg[i] <= legal_cfg(wdata_reg[7:0]);
        if (wr_addr && wr_idx == 6'(i) && !addr_lock[i])
          addr_reg[i] <= (PA_W-2)'(merge_bytes(32'(addr_reg[i]), wdata_reg,
                                               wstrb_reg));
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // access check

  logic [NE-1:0] any_hit;
  logic [NE-1:0] full_hit;
  logic [NE-1:0] perm_ok;
  logic [NE-1:0] lower_hit;
  logic [NE-1:0] winner;

  wire logic [1:0]  eff_priv = i_chk_walk ? phys_mem_access_checker_pkg::PRIV_SUPERVISOR
                                          : i_chk_priv;
  wire logic        is_mach  = eff_priv == phys_mem_access_checker_pkg::PRIV_MACHINE;
  wire logic [3:0]  acc_len  = 4'h1 << i_chk_size;
  wire logic [PA_W:0] acc_lo = {1'b0, i_chk_addr};
  wire logic [PA_W:0] acc_hi = acc_lo + (PA_W+1)'(acc_len) - (PA_W+1)'(1);

  generate
    for (g = 0; g < NE; g++) begin : g_entry
      region_match #(
        .PA_W (PA_W)
      ) u_match (
        .i_mode      (cfg_reg[g][`PMAC_CFG_A_LSB +: 2]),
        .i_addr      (addr_reg[g]),
        .i_prev_addr (addr_reg[(g > 0) ? g - 1 : 0]),
        .i_first     (g == 0),
        .i_lo        (acc_lo),
        .i_hi        (acc_hi),
        .o_any       (any_hit[g]),
        .o_full      (full_hit[g])
      );
      wire logic kind_perm =
        (i_chk_kind == phys_mem_access_checker_pkg::ACC_FETCH) ? cfg_reg[g][`PMAC_CFG_X] :
        (i_chk_kind == phys_mem_access_checker_pkg::ACC_LOAD)  ? cfg_reg[g][`PMAC_CFG_R] :
                                                                 cfg_reg[g][`PMAC_CFG_W];
      assign perm_ok[g] = full_hit[g] &&
        ((is_mach && !cfg_lock[g]) || kind_perm);
      if (g == 0) begin : g_first
        assign lower_hit[g] = 1'b0;
      end else begin : g_rest
        assign lower_hit[g] = lower_hit[g-1] || any_hit[g-1];
      end
      assign winner[g] = any_hit[g] && !lower_hit[g];
    end
  endgenerate

  // all entries in parallel, current settings, no caching
  wire logic any_match  = (N_ENTRIES > 0) && |any_hit;
  wire logic win_pass   = |(winner & perm_ok);
  wire logic chk_pass   = (N_ENTRIES == 0) ? 1'b1 :
                          any_match ? win_pass :
                          is_mach;
  wire logic size_ok    = {30'h0, i_chk_size} <= SIZE_MAX;
  wire logic chk_fail   = !chk_pass || !size_ok;
  wire logic [1:0] cause = (i_chk_kind == phys_mem_access_checker_pkg::ACC_FETCH) ?
                             phys_mem_access_checker_pkg::FAULT_INSN :
                           (i_chk_kind == phys_mem_access_checker_pkg::ACC_LOAD) ?
                             phys_mem_access_checker_pkg::FAULT_LOAD :
                             phys_mem_access_checker_pkg::FAULT_STORE;

  logic        done_reg;
  logic        fault_reg;
  logic [1:0]  cause_reg;
  logic        insn_acc_reg;
  logic        insn_done_reg;
  logic        insn_fault_reg;
  logic [31:0] fault_addr_reg;
  logic [31:0] fault_cnt_reg;

  // every access, walks included, is checked here
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      done_reg  <= 1'b0;
      fault_reg <= 1'b0;
      cause_reg <= phys_mem_access_checker_pkg::FAULT_INSN;
    end else begin
      done_reg <= i_chk_valid;
      if (i_chk_valid) begin
        fault_reg <= chk_fail;
        cause_reg <= cause;
      end
    end
  end

  // instruction fault collects every part, earlier passes included
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      insn_acc_reg   <= 1'b0;
      insn_done_reg  <= 1'b0;
      insn_fault_reg <= 1'b0;
    end else begin
      insn_done_reg <= i_chk_valid && i_chk_last;
      if (i_chk_valid && i_chk_last) begin
        insn_fault_reg <= insn_acc_reg || chk_fail;
        insn_acc_reg   <= 1'b0;
      end else if (i_chk_valid) begin
        insn_acc_reg <= insn_acc_reg || chk_fail;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fault_addr_reg <= '0;
      fault_cnt_reg  <= '0;
    end else if (i_chk_valid && chk_fail) begin
      fault_addr_reg <= 32'(i_chk_addr >> 2);
      fault_cnt_reg  <= fault_cnt_reg + 32'h0000_0001;
    end
  end

  assign o_chk_done   = done_reg;
  assign o_chk_fault  = fault_reg;
  assign o_chk_cause  = cause_reg;
  assign o_insn_done  = insn_done_reg;
  assign o_insn_fault = insn_fault_reg;

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  wire logic       ar_fire   = i_axi_arvalid && o_axi_arready;
  wire logic [1:0] rd_region = i_axi_araddr[`PMAC_REGION_LSB +: 2];
  wire logic [5:0] rd_idx    = i_axi_araddr[`PMAC_IDX_LSB +: 6];
  wire logic       rd_entry  = ({26'h0, rd_idx} < N_ENTRIES) &&
                               (i_axi_araddr[AXI_AW-1:`PMAC_REGION_LSB+2] == '0);
  wire logic [5:0] rd_sel    = rd_entry ? rd_idx : 6'h00;
  wire logic       rd_cfg    = rd_entry && rd_region == 2'h0;
  wire logic       rd_addr   = rd_entry && rd_region == 2'h1;
  wire logic       rd_st     = i_axi_araddr == AXI_AW'(`PMAC_STATUS_OFS);
  wire logic       rd_fa     = i_axi_araddr == AXI_AW'(`PMAC_FAULT_ADDR_OFS);
  wire logic       rd_fc     = i_axi_araddr == AXI_AW'(`PMAC_FAULT_CNT_OFS);
  wire logic [31:0] status_word = {28'h0, insn_fault_reg, cause_reg, fault_reg};
  wire logic [31:0] rd_word =
    rd_cfg  ? {24'h0, cfg_reg[int'(rd_sel) % NE]} :
    rd_addr ? 32'(addr_reg[int'(rd_sel) % NE]) :
    rd_st   ? status_word :
    rd_fa   ? fault_addr_reg :
    rd_fc   ? fault_cnt_reg : 32'h0000_0000;
  wire logic       rd_ok     = rd_cfg || rd_addr || rd_st || rd_fa || rd_fc;

  assign o_axi_arready = !rvalid_reg;
  assign o_axi_rvalid  = rvalid_reg;
  assign o_axi_rdata   = rdata_reg;
  assign o_axi_rresp   = rresp_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= `PMAC_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_ok ? `PMAC_RESP_OKAY : `PMAC_RESP_SLVERR;
    end else if (i_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : phys_mem_access_checker

// >>> phys_mem_access_checker_monitor.sv
`timescale 1ns/10ps

module phys_mem_access_checker_monitor (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // register bus
  input wire logic        i_axi_awvalid,
  input wire logic        o_axi_awready,
  input wire logic        i_axi_wvalid,
  input wire logic        o_axi_wready,
  input wire logic        o_axi_bvalid,
  input wire logic        i_axi_bready,
  input wire logic        o_axi_rvalid,
  input wire logic        i_axi_rready,
  input wire logic [31:0] o_axi_rdata,
  // access check
  input wire logic        i_chk_valid,
  input wire logic [1:0]  i_chk_kind,
  input wire logic        i_chk_last,
  input wire logic        o_chk_done,
  input wire logic        o_chk_fault,
  input wire logic [1:0]  o_chk_cause,
  input wire logic        o_insn_done,
  input wire logic        o_insn_fault
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  chk_done_follows: assert property (i_chk_valid |=> o_chk_done)
    else $error("check result missing");
  chk_done_idle: assert property (!i_chk_valid |=> !o_chk_done)
    else $error("check result without request");
  chk_cause_kind: assert property (i_chk_valid ##1 o_chk_fault |-> o_chk_cause == $past(i_chk_kind))
    else $error("fault cause differs from access kind");
  chk_fault_hold: assert property (!i_chk_valid |=> $stable(o_chk_fault) && $stable(o_chk_cause))
    else $error("fault result changed without request");
  chk_insn_done: assert property (i_chk_valid && i_chk_last |=> o_insn_done)
    else $error("instruction result missing");
  chk_insn_fault: assert property ((i_chk_valid && i_chk_last) ##1 o_chk_fault |-> o_insn_fault)
    else $error("failed last part left instruction clean");
  chk_wr_answer: assert property (i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready
                                  |-> ##2 o_axi_bvalid)
    else $error("write response late");
  chk_b_hold: assert property (o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid)
    else $error("write response dropped");
  chk_r_hold: assert property (o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
    else $error("read data dropped");

  cov_fault: cover property (o_chk_done && o_chk_fault);
  cov_insn_fault: cover property (o_insn_done && o_insn_fault);
  cov_write: cover property (o_axi_bvalid && i_axi_bready);
endmodule : phys_mem_access_checker_monitor

bind phys_mem_access_checker phys_mem_access_checker_monitor i_phys_mem_access_checker_monitor (
  .i_clk(i_clk), .i_rst(i_rst), .i_axi_awvalid(i_axi_awvalid), .o_axi_awready(o_axi_awready),
  .i_axi_wvalid(i_axi_wvalid), .o_axi_wready(o_axi_wready), .o_axi_bvalid(o_axi_bvalid),
  .i_axi_bready(i_axi_bready), .o_axi_rvalid(o_axi_rvalid), .i_axi_rready(i_axi_rready),
  .o_axi_rdata(o_axi_rdata), .i_chk_valid(i_chk_valid), .i_chk_kind(i_chk_kind),
  .i_chk_last(i_chk_last), .o_chk_done(o_chk_done), .o_chk_fault(o_chk_fault),
  .o_chk_cause(o_chk_cause), .o_insn_done(o_insn_done), .o_insn_fault(o_insn_fault)
);

// >>> access_source.sv
`timescale 1ns/10ps

module access_source (
  // clock
  input  wire logic        i_clk,
  // request to the checker
  output logic             o_valid,
  output logic [33:0]      o_addr,
  output logic [1:0]       o_size,
  output logic [1:0]       o_kind,
  output logic [1:0]       o_priv,
  output logic             o_walk,
  output logic             o_last,
  // result from the checker
  input  wire logic        i_done,
  input  wire logic        i_fault,
  input  wire logic [1:0]  i_cause,
  input  wire logic        i_insn_done,
  input  wire logic        i_insn_fault
);
  initial begin
    o_valid = 1'b0;
    o_addr  = '0;
    o_size  = '0;
    o_kind  = '0;
    o_priv  = '0;
    o_walk  = 1'b0;
    o_last  = 1'b0;
  end

  // one access, held for one edge, result read at the falling edge after it
  task automatic issue(input logic [33:0] a, input logic [1:0] sz, k, p, input logic w, l,
                       output logic [5:0] res);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_addr  <= a;
    o_size  <= sz;
    o_kind  <= k;
    o_priv  <= p;
    o_walk  <= w;
    o_last  <= l;
    @(posedge i_clk);
    // released lines show the inverse, not the old value
    o_valid <= 1'b0;
    o_addr  <= ~a;
    o_size  <= ~sz;
    o_kind  <= ~k;
    o_priv  <= ~p;
    o_walk  <= ~w;
    o_last  <= ~l;
    @(negedge i_clk);
    res = {i_done, i_fault, i_cause, i_insn_done, i_insn_fault};
  endtask : issue
endmodule : access_source

// >>> tb_phys_mem_access_checker.sv
`timescale 1ns/10ps

module tb_phys_mem_access_checker;
  localparam logic [1:0] fe = 2'(phys_mem_access_checker_pkg::ACC_FETCH);
  localparam logic [1:0] ld = 2'(phys_mem_access_checker_pkg::ACC_LOAD);
  localparam logic [1:0] st = 2'(phys_mem_access_checker_pkg::ACC_STORE);
  localparam logic [1:0] pu = 2'(phys_mem_access_checker_pkg::PRIV_USER);
  localparam logic [1:0] ps = 2'(phys_mem_access_checker_pkg::PRIV_SUPERVISOR);
  localparam logic [1:0] pm = 2'(phys_mem_access_checker_pkg::PRIV_MACHINE);

  logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, valid, walk, last;
  logic        done, fault, insn_done, insn_fault;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, size, kind, priv, cause;
  logic [33:0] addr;
  int          n_mismatch, n_tests, cycles;

  phys_mem_access_checker i_phys_mem_access_checker (
    .i_clk(clk), .i_rst(rst), .i_axi_awvalid(awvalid), .o_axi_awready(awready),
    .i_axi_awaddr(awaddr), .i_axi_wvalid(wvalid), .o_axi_wready(wready), .i_axi_wdata(wdata),
    .i_axi_wstrb(wstrb), .o_axi_bvalid(bvalid), .i_axi_bready(bready), .o_axi_bresp(bresp),
    .i_axi_arvalid(arvalid), .o_axi_arready(arready), .i_axi_araddr(araddr),
    .i_axi_rready(rready), .o_axi_rvalid(rvalid), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
    .i_chk_valid(valid), .i_chk_addr(addr), .i_chk_size(size), .i_chk_kind(kind),
    .i_chk_priv(priv), .i_chk_walk(walk), .i_chk_last(last), .o_chk_done(done),
    .o_chk_fault(fault), .o_chk_cause(cause), .o_insn_done(insn_done), .o_insn_fault(insn_fault)
  );

  access_source i_access_source (
    .i_clk(clk), .o_valid(valid), .o_addr(addr), .o_size(size), .o_kind(kind), .o_priv(priv),
    .o_walk(walk), .o_last(last), .i_done(done), .i_fault(fault), .i_cause(cause),
    .i_insn_done(insn_done), .i_insn_fault(insn_fault)
  );

  always #2.5 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 4000) begin
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_reset();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hit, w_hit, b_hit;
    b_hit = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    while (!b_hit) begin
      @(negedge clk);
      aw_hit = awvalid && awready;
      w_hit  = wvalid && wready;
      b_hit  = bvalid && bready;
      if (b_hit) check({30'h0, bresp}, {30'h0, er});
      @(posedge clk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_hit, r_hit;
    r_hit = 1'b0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    while (!r_hit) begin
      @(negedge clk);
      ar_hit = arvalid && arready;
      r_hit  = rvalid && rready;
      if (r_hit) check(rdata, ed);
      if (r_hit) check({30'h0, rresp}, {30'h0, er});
      @(posedge clk);
      if (ar_hit) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : rd

  task automatic acc(input logic [33:0] a, input logic [1:0] sz, k, p,
                     input logic w, l, ef, ei);
    logic [5:0] r;
    i_access_source.issue(a, sz, k, p, w, l, r);
    check({31'h0, r[5]}, 32'h1);
    check({31'h0, r[4]}, {31'h0, ef});
    if (ef) check({30'h0, r[3:2]}, {30'h0, k});
    check({31'h0, r[1]}, {31'h0, l});
    if (l) check({31'h0, r[0]}, {31'h0, ei});
  endtask : acc

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hF;
    {n_mismatch, n_tests, cycles} = '0;
    do_reset();
    rd(12'h000, 32'h0, 2'h0);
    rd(12'h100, 32'h0, 2'h0);
    rd(12'h040, 32'h0, 2'h2);
    acc(34'h0, 2'h2, ld, pm, 1'b0, 1'b1, 1'b0, 1'b0);
    acc(34'h0, 2'h2, ld, pu, 1'b0, 1'b1, 1'b1, 1'b1);
    acc(34'h0, 2'h2, fe, ps, 1'b0, 1'b1, 1'b1, 1'b1);
    // quad at 0xC read only, range 0xC..0xFFF all, pow2 0x2000 16 bytes read only
    wr(12'h100, 32'h3, 2'h0);
    wr(12'h000, 32'h11, 2'h0);
    wr(12'h104, 32'h400, 2'h0);
    wr(12'h004, 32'h0F, 2'h0);
    wr(12'h108, 32'h801, 2'h0);
    wr(12'h008, 32'h19, 2'h0);
    acc(34'hC, 2'h2, ld, pu, 1'b0, 1'b1, 1'b0, 1'b0);
    acc(34'h8, 2'h3, ld, pu, 1'b0, 1'b1, 1'b1, 1'b1);
    acc(34'hC, 2'h2, st, pu, 1'b0, 1'b1, 1'b1, 1'b1);
    acc(34'hC, 2'h2, fe, ps, 1'b0, 1'b1, 1'b1, 1'b1);
    acc(34'hC, 2'h2, st, pm, 1'b0, 1'b1, 1'b0, 1'b0);
    acc(34'h20, 2'h2, st, pu, 1'b0, 1'b1, 1'b0, 1'b0);
    acc(34'h0, 2'h2, st, pu, 1'b0, 1'b1, 1'b1, 1'b1);
    acc(34'hFFE, 2'h2, ld, pu, 1'b0, 1'b1, 1'b1, 1'b1);
    acc(34'h1000, 2'h0, ld, pu, 1'b0, 1'b1, 1'b1, 1'b1);
    acc(34'h200C, 2'h2, ld, pu, 1'b0, 1'b1, 1'b0, 1'b0);
    acc(34'h2010, 2'h0, ld, pu, 1'b0, 1'b1, 1'b1, 1'b1);
    acc(34'h3000, 2'h2, ld, pm, 1'b1, 1'b1, 1'b1, 1'b1);
    acc(34'h3000, 2'h2, ld, pm, 1'b0, 1'b1, 1'b0, 1'b0);
    acc(34'h0, 2'h2, st, pu, 1'b0, 1'b0, 1'b1, 1'b0);
    acc(34'h20, 2'h2, st, pu, 1'b0, 1'b1, 1'b0, 1'b1);
    acc(34'h20, 2'h2, st, pu, 1'b0, 1'b1, 1'b0, 1'b0);
    wr(12'h008, 32'h0, 2'h0);
    acc(34'h200C, 2'h2, ld, pu, 1'b0, 1'b1, 1'b1, 1'b1);
    wr(12'h000, 32'h91, 2'h0);
    acc(34'hC, 2'h2, st, pm, 1'b0, 1'b1, 1'b1, 1'b1);
    acc(34'hC, 2'h2, ld, pm, 1'b0, 1'b1, 1'b0, 1'b0);
    wr(12'h000, 32'h0, 2'h0);
    wr(12'h100, 32'h5, 2'h0);
    rd(12'h000, 32'h91, 2'h0);
    rd(12'h100, 32'h3, 2'h0);
    rd(12'h200, 32'h2, 2'h0);
    rd(12'h204, 32'h3, 2'h0);
    rd(12'h208, 32'hD, 2'h0);
    do_reset();
    rd(12'h000, 32'h0, 2'h0);
    test_done();
  end
endmodule : tb_phys_mem_access_checker
